/* File: rtl/cardseq_pkg.sv */
package cardseq_pkg;

   // system clock and the card clock made from it
   localparam int MCLK_HZ        = 40_000_000;
   localparam int MCLK_PERIOD_NS = 25;
   localparam int CARD_CLK_HZ    = 5_000_000;
   localparam int CCLK_HALF_CYC  = MCLK_HZ / (2 * CARD_CLK_HZ);

   // nominal real-time timebase, used until the first period is measured
   localparam int RTC_HZ        = 32_000;
   localparam int RTC_PERIOD_NS = 1_000_000_000 / RTC_HZ;
   localparam int RTC_DEF_CYC   = RTC_PERIOD_NS / MCLK_PERIOD_NS;

   // activation intervals, in card clock cycles
   localparam int IO_REL_CYC  = 200;
   localparam int ATR_MIN_CYC = 400;
   localparam int RST_LOW_DEF = 40_000;
   localparam int ATR_MAX_DEF = 40_000;

   // card clock to data rate ratios
   localparam int ETU_STD  = 372;
   localparam int ETU_FAST = 16;

   // counter widths
   localparam int DIV_W  = 3;
   localparam int CYC_W  = 17;
   localparam int TMR_W  = 16;
   localparam int DCNT_W = 18;
   localparam int ETU_W  = 9;

   // sized compare and load values
   localparam logic [DIV_W-1:0] DIV_LAST      = DIV_W'(CCLK_HALF_CYC - 1);
   localparam logic [CYC_W-1:0] IO_REL_AT     = CYC_W'(IO_REL_CYC - 1);
   localparam logic [CYC_W-1:0] ATR_MIN_AT    = CYC_W'(ATR_MIN_CYC);
   localparam logic [CYC_W-1:0] CYC_PRE_T0    = 17'h1FFFF;
   localparam logic [TMR_W-1:0] RTC_DEF_PER   = TMR_W'(RTC_DEF_CYC);
   localparam logic [ETU_W-1:0] ETU_STD_LAST  = ETU_W'(ETU_STD - 1);
   localparam logic [ETU_W-1:0] ETU_FAST_LAST = ETU_W'(ETU_FAST - 1);

   typedef enum logic [2:0] {ST_IDLE, ST_POWER, ST_T0, ST_RST_LOW, ST_ATR_WAIT, ST_ACTIVE, ST_DEACT} seq_state_t;
   typedef enum logic [1:0] {DS_LEAD, DS_RST, DS_CLK, DS_IO} deact_step_t;

   // asynchronous card-side inputs and the timebase, synchronised together
   typedef struct packed {
      logic present;
      logic data;
      logic rtc;
   } card_in_t;

   // registered card-side outputs except the clock
   typedef struct packed {
      logic supply_en;
      logic reset;
      logic data_o;
      logic data_oe;
   } card_pins_t;

   localparam card_in_t   IN_IDLE  = '{present: 1'b0, data: 1'b1, rtc: 1'b0};
   localparam card_pins_t PINS_OFF = '{supply_en: 1'b0, reset: 1'b0, data_o: 1'b0, data_oe: 1'b1};

endpackage

/* File: rtl/smart_card_activation_seq.sv */
`timescale 1ns/1ps
module smart_card_activation_seq
   import cardseq_pkg::*;
#(
   parameter int RST_LOW_CYC = RST_LOW_DEF,
   parameter int ATR_MAX_CYC = ATR_MAX_DEF
)
(
   // clock and reset
   input  wire logic MCLK_I,
   input  wire logic RST_N_I,
   // processor control
   input  wire logic ACTIVATE_I,
   input  wire logic POWER_DOWN_I,
   input  wire logic AUTO_PD_I,
   input  wire logic RESET_MODE_I,
   input  wire logic RATIO_SEL_I,
   input  wire logic ERR_CLR_I,
   // asynchronous inputs
   input  wire logic RTC_CLK_I,
   input  wire logic CARD_PRESENCE_DETECT_I,
   input  wire logic CARD_DATA_LINE_I,
   // card pins
   output logic      CARD_CLOCK_OUT_O,
   output logic      CARD_RESET_OUT_O,
   output logic      CARD_DATA_LINE_O,
   output logic      CARD_DATA_LINE_OE_O,
   output logic      CARD_SUPPLY_ENABLE_O,
   // status
   output logic      ACTIVE_O,
   output logic      ANSWER_OK_O,
   output logic      ERR_EARLY_O,
   output logic      ERR_NO_ANSWER_O,
   output logic      ETU_TICK_O
);

   card_in_t                in_s1_q;
   card_in_t                in_s2_q;
   logic                    rtc_prev_q;
   logic                    data_prev_q;
   logic [TMR_W-1:0]        rtc_cnt_q;
   logic [TMR_W-1:0]        rtc_per_q;
   logic                    rtc_seen_q;
   logic [DIV_W-1:0]        cdiv_q;
   logic                    cclk_q;
   logic                    clk_run_q;
   logic [ETU_W-1:0]        etu_cnt_q;
   logic                    etu_tick_q;
   seq_state_t              state_q;
   deact_step_t             step_q;
   card_pins_t              pins_q;
   logic                    cfg_low_q;
   logic [CYC_W-1:0]        cyc_q;
   logic [TMR_W-1:0]        tmr_q;
   logic [TMR_W-1:0]        per_lock_q;
   logic                    ans_ok_q;
   logic                    err_early_q;
   logic                    err_noans_q;
   logic [DCNT_W-1:0]       dcnt_q;
   logic                    rtc_rise;
   logic                    cc_rise;
   logic                    ans_edge;
   logic                    removal;
   logic                    pd_req;
   logic                    fire;
   logic                    early_ev;
   logic                    ans_ok_ev;
   logic                    noans_ev;

   // multiples of the latched timebase period, in system clock cycles
   function automatic logic [DCNT_W-1:0] per_times(input logic [TMR_W-1:0] p, input logic [2:0] k);
      per_times = DCNT_W'(p) * DCNT_W'(k);
   endfunction

   // two-stage synchronisers; the first stage feeds only the second
   always_ff @(posedge MCLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         in_s1_q     <= IN_IDLE;
         in_s2_q     <= IN_IDLE;
         rtc_prev_q  <= 1'b0;
         data_prev_q <= 1'b1;
      end
      else
      begin
         in_s1_q     <= '{present: CARD_PRESENCE_DETECT_I, data: CARD_DATA_LINE_I, rtc: RTC_CLK_I};
         in_s2_q     <= in_s1_q;
         rtc_prev_q  <= in_s2_q.rtc;
         data_prev_q <= in_s2_q.data;
      end
   end

   // decoded events
   always_comb
   begin
      rtc_rise  = in_s2_q.rtc & ~rtc_prev_q;
      cc_rise   = clk_run_q && (cdiv_q == DIV_LAST) && !cclk_q;
      ans_edge  = data_prev_q & ~in_s2_q.data;                      // start bit of the answer
      removal   = ~in_s2_q.present;
      pd_req    = removal | POWER_DOWN_I | AUTO_PD_I;
      fire      = (tmr_q == '0);
      early_ev  = ans_edge && ((state_q == ST_RST_LOW) ||
                  ((state_q == ST_ATR_WAIT) && (cyc_q < ATR_MIN_AT)));
      ans_ok_ev = ans_edge && (state_q == ST_ATR_WAIT) && (cyc_q >= ATR_MIN_AT) &&
                  (cyc_q <= CYC_W'(ATR_MAX_CYC));
      noans_ev  = (state_q == ST_ATR_WAIT) && (cyc_q > CYC_W'(ATR_MAX_CYC)) && !ans_edge;
   end

   // timebase period measured in system clocks, so that a step spans one real period
   // rather than the 0 to 1 periods a plain edge wait would give
   always_ff @(posedge MCLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         rtc_cnt_q  <= '0;
         rtc_per_q  <= RTC_DEF_PER;
         rtc_seen_q <= 1'b0;
      end
      else if (rtc_rise)
      begin
         rtc_cnt_q  <= '0;
         rtc_seen_q <= 1'b1;
         if (rtc_seen_q && (rtc_cnt_q != '0))
            rtc_per_q <= rtc_cnt_q + 1'b1;
      end
      else if (rtc_cnt_q != '1)
         rtc_cnt_q <= rtc_cnt_q + 1'b1;
   end

   // card clock divider; a stop forces the clock low at once
   always_ff @(posedge MCLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         cdiv_q <= '0;
         cclk_q <= 1'b0;
      end
      else if (!clk_run_q)
      begin
         cdiv_q <= '0;
         cclk_q <= 1'b0;
      end
      else if (cdiv_q == DIV_LAST)
      begin
         cdiv_q <= '0;
         cclk_q <= ~cclk_q;
      end
      else
         cdiv_q <= cdiv_q + 1'b1;
   end

   // data-rate tick for the character layer
   always_ff @(posedge MCLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         etu_cnt_q  <= '0;
         etu_tick_q <= 1'b0;
      end
      else
      begin
         etu_tick_q <= 1'b0;
         if (!clk_run_q)
            etu_cnt_q <= '0;
         else if (cc_rise)
         begin
            if (etu_cnt_q >= (RATIO_SEL_I ? ETU_FAST_LAST : ETU_STD_LAST))
            begin
               etu_cnt_q  <= '0;
               etu_tick_q <= 1'b1;
            end
            else
               etu_cnt_q <= etu_cnt_q + 1'b1;
         end
      end
   end

   // activation and deactivation sequencer
   always_ff @(posedge MCLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         state_q    <= ST_IDLE;
         step_q     <= DS_LEAD;
         pins_q     <= PINS_OFF;
         clk_run_q  <= 1'b0;
         cfg_low_q  <= 1'b0;
         cyc_q      <= '0;
         tmr_q      <= '0;
         per_lock_q <= RTC_DEF_PER;
      end
      else
      begin
         if (cc_rise)
            cyc_q <= cyc_q + 1'b1;
         if (!fire)
            tmr_q <= tmr_q - 1'b1;
         case (state_q)
            ST_IDLE:
               if (ACTIVATE_I && in_s2_q.present)
               begin
                  state_q          <= ST_POWER;
                  pins_q.supply_en <= 1'b1;
                  cfg_low_q        <= RESET_MODE_I;
                  tmr_q            <= rtc_per_q - 1'b1;               // supply settles one period
               end
            ST_POWER:
               if (fire)
               begin
                  clk_run_q    <= 1'b1;
                  cyc_q        <= CYC_PRE_T0;                         // first edge wraps to zero at T0
                  pins_q.reset <= ~cfg_low_q;
                  state_q      <= ST_T0;
               end
            ST_T0:
               if (cyc_q == IO_REL_AT)
               begin
                  pins_q.data_o  <= 1'b1;
                  pins_q.data_oe <= 1'b0;
                  state_q        <= cfg_low_q ? ST_RST_LOW : ST_ATR_WAIT;
               end
            ST_RST_LOW:
               if (cyc_q == CYC_W'(RST_LOW_CYC))
               begin
                  pins_q.reset <= 1'b1;
                  cyc_q        <= '0;
                  state_q      <= ST_ATR_WAIT;
               end
            ST_ATR_WAIT:
               if (ans_ok_ev)
                  state_q <= ST_ACTIVE;
            ST_ACTIVE:
               state_q <= ST_ACTIVE;                                  // reset held high until deactivation
            ST_DEACT:
               if (fire)
               begin
                  tmr_q <= per_lock_q - 1'b1;
                  case (step_q)
                     DS_LEAD: pins_q.reset   <= 1'b0;
                     DS_RST:  clk_run_q      <= 1'b0;
                     DS_CLK:
                     begin
                        pins_q.data_o  <= 1'b0;
                        pins_q.data_oe <= 1'b1;
                     end
                     default:
                     begin
                        pins_q.supply_en <= 1'b0;
                        state_q          <= ST_IDLE;
                     end
                  endcase
                  step_q <= deact_step_t'(step_q + 1'b1);
               end
            default:
               state_q <= ST_IDLE;
         endcase
         // any power-down cause preempts activation; the period is frozen for the whole sequence
         if ((state_q != ST_IDLE) && (state_q != ST_DEACT) && (pd_req || noans_ev))
         begin
            state_q    <= ST_DEACT;
            step_q     <= DS_LEAD;
            tmr_q      <= rtc_per_q - 1'b1;
            per_lock_q <= rtc_per_q;
         end
      end
   end

   // status flags; a set in the cycle of a clear wins
   always_ff @(posedge MCLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         ans_ok_q    <= 1'b0;
         err_early_q <= 1'b0;
         err_noans_q <= 1'b0;
      end
      else
      begin
         if (ans_ok_ev)
            ans_ok_q <= 1'b1;
         else if (state_q == ST_IDLE)
            ans_ok_q <= 1'b0;
         err_early_q <= early_ev | (err_early_q & ~ERR_CLR_I);
         err_noans_q <= noans_ev | (err_noans_q & ~ERR_CLR_I);
      end
   end

   // system clocks since deactivation began, read only by the checks below
   always_ff @(posedge MCLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         dcnt_q <= '0;
      else if (state_q != ST_DEACT)
         dcnt_q <= '0;
      else
         dcnt_q <= dcnt_q + 1'b1;
   end

   // port drive
   assign CARD_CLOCK_OUT_O     = cclk_q;
   assign CARD_RESET_OUT_O     = pins_q.reset;
   assign CARD_DATA_LINE_O     = pins_q.data_o;
   assign CARD_DATA_LINE_OE_O  = pins_q.data_oe;
   assign CARD_SUPPLY_ENABLE_O = pins_q.supply_en;
   assign ACTIVE_O             = (state_q == ST_ACTIVE);
   assign ANSWER_OK_O          = ans_ok_q;
   assign ERR_EARLY_O          = err_early_q;
   assign ERR_NO_ANSWER_O      = err_noans_q;
   assign ETU_TICK_O           = etu_tick_q;

   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RST_N_I);

   sequence s_deact_enter;
      (state_q != ST_DEACT) ##1 (state_q == ST_DEACT);
   endsequence

   sequence s_rst_fall;
      $fell(pins_q.reset) && (state_q == ST_DEACT);
   endsequence

   chk_clock_start: assert property ($rose(clk_run_q) |-> ##[1:8] cclk_q)
      else $error("card clock did not start");

   chk_io_release: assert property ((state_q == ST_T0) && (cyc_q == IO_REL_AT) |=> !pins_q.data_oe && pins_q.data_o)
      else $error("data line not released by cycle 200");

   chk_rst_low_len: assert property ($rose(pins_q.reset) && cfg_low_q |-> $past(cyc_q) == CYC_W'(RST_LOW_CYC))
      else $error("reset low interval wrong");

   chk_rst_high_hold: assert property ($fell(pins_q.reset) |-> state_q == ST_DEACT)
      else $error("reset fell outside deactivation");

   chk_answer_window: assert property ($rose(ans_ok_q) |-> ($past(cyc_q) >= ATR_MIN_AT) &&
                                       ($past(cyc_q) <= CYC_W'(ATR_MAX_CYC)))
      else $error("answer accepted outside window");

   chk_removal_start: assert property ((state_q == ST_ACTIVE) && removal |=> state_q == ST_DEACT)
      else $error("removal did not start deactivation");

   chk_pd_rst_lead: assert property (s_rst_fall |-> dcnt_q == per_times(per_lock_q, 3'h1))
      else $error("reset did not fall one period after the request");

   chk_clk_stop_gap: assert property ($fell(clk_run_q) |-> dcnt_q == per_times(per_lock_q, 3'h2))
      else $error("clock stop not one period after reset low");

   chk_io_low_gap: assert property ($rose(pins_q.data_oe) && (state_q == ST_DEACT) |->
                                    dcnt_q == per_times(per_lock_q, 3'h3))
      else $error("data low not two periods after reset low");

   // supply drop is the last step, so it is seen in the same cycle that the sequence returns to idle
   chk_supply_gap: assert property ($fell(pins_q.supply_en) |-> ($past(state_q) == ST_DEACT) &&
                                    (dcnt_q == per_times(per_lock_q, 3'h4)))
      else $error("supply drop not three periods after reset low");

   // every cause enters with the same first step and a full lead period loaded
   chk_deact_entry: assert property (s_deact_enter |-> (step_q == DS_LEAD) &&
                                     (tmr_q == per_lock_q - 1'b1))
      else $error("deactivation did not start with a full lead period");

   chk_timeout_flag: assert property (noans_ev |=> err_noans_q && (state_q == ST_DEACT))
      else $error("missing answer not flagged");

   chk_early_flag: assert property (ans_edge && (state_q == ST_RST_LOW) |=> err_early_q)
      else $error("answer during reset low not flagged");

endmodule

/* File: test/card_model.sv */
`timescale 1ns/1ps
module card_model
(
   // card contacts
   input  wire logic        card_clock_i,
   input  wire logic        card_supply_i,
   // answer start in card clocks from T0, zero means silent
   input  wire logic [15:0] answer_at_i,
   // pulls the shared data line low
   output logic             data_low_o
);
   logic [15:0] cnt_q = 16'h0000;

   // a card only counts while powered, losing supply wipes its state
   always @(posedge card_clock_i or negedge card_supply_i)
   begin
      if (!card_supply_i)
         cnt_q <= 16'h0000;
      else
         cnt_q <= cnt_q + 16'h0001;
   end

   // start bit two card clocks long, then the line goes back to the pull-up
   assign data_low_o = card_supply_i && (answer_at_i != 16'h0000) && (cnt_q >= answer_at_i) &&
                       (cnt_q < answer_at_i + 16'h0002);
endmodule

/* File: test/testbench.sv */
`timescale 1ns/1ps
module testbench
   import cardseq_pkg::*;
;
   localparam int RST_LOW = 600;
   localparam int ATR_MAX = 900;
   localparam int P       = 8; // timebase period in system clocks
   logic        mclk, rst_n, activate, power_down, auto_pd, reset_mode, ratio_sel, err_clr, rtc_clk, present;
   logic        card_clk, card_rst, data_o, data_oe, supply, active, answer_ok, err_early, err_none, etu_tick;
   logic        card_low;
   logic        data_line;
   logic [15:0] answer_at;
   logic        clk_prev = 1'h0;
   int          n_rise = 0;
   int          n_errors;
   int          checks_done;

   smart_card_activation_seq #(.RST_LOW_CYC(RST_LOW), .ATR_MAX_CYC(ATR_MAX)) u_dut
   (
      .MCLK_I(mclk), .RST_N_I(rst_n), .ACTIVATE_I(activate), .POWER_DOWN_I(power_down),
      .AUTO_PD_I(auto_pd), .RESET_MODE_I(reset_mode), .RATIO_SEL_I(ratio_sel), .ERR_CLR_I(err_clr),
      .RTC_CLK_I(rtc_clk), .CARD_PRESENCE_DETECT_I(present), .CARD_DATA_LINE_I(data_line),
      .CARD_CLOCK_OUT_O(card_clk), .CARD_RESET_OUT_O(card_rst), .CARD_DATA_LINE_O(data_o),
      .CARD_DATA_LINE_OE_O(data_oe), .CARD_SUPPLY_ENABLE_O(supply), .ACTIVE_O(active),
      .ANSWER_OK_O(answer_ok), .ERR_EARLY_O(err_early), .ERR_NO_ANSWER_O(err_none), .ETU_TICK_O(etu_tick)
   );

   card_model u_card
   (
      .card_clock_i(card_clk), .card_supply_i(supply), .answer_at_i(answer_at), .data_low_o(card_low)
   );

   // open-drain style wire with pull-up: low if either side pulls it low
   assign data_line = !((data_oe && !data_o) || card_low);

   // system clock and a free-running timebase of unrelated phase
   initial
   begin
      mclk = 1'h0;
      forever #12.5 mclk = ~mclk;
   end
   initial
   begin
      rtc_clk = 1'h0;
      #37;
      forever #100 rtc_clk = ~rtc_clk;
   end

   // card clock rises since supply came up, first one is T0
   always @(posedge mclk)
   begin
      clk_prev <= card_clk;
      if (!supply)
         n_rise <= 0;
      else if (card_clk && !clk_prev)
         n_rise <= n_rise + 1;
   end

   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
      end
   endtask

   function automatic logic cond(input int what);
      case (what)
         0: return supply;
         1: return card_clk;
         2: return !data_oe;
         3: return card_rst;
         4: return answer_ok | err_none;
         5: return !card_rst;
         6: return !supply;
         default: return etu_tick;
      endcase
   endfunction

   // bounded wait, a hang ends the run through the closing report
   task automatic await(input int what, input int limit, output int waited);
      waited = 0;
      while (cond(what) !== 1'h1 && waited < limit)
      begin
         @(posedge mclk);
         #1;
         waited++;
      end
      if (cond(what) !== 1'h1)
      begin
         n_errors++;
         $display("unexpected wait %0d: expected done, seen timeout", what);
         report_and_stop();
      end
   endtask

   task automatic start_session(input logic mode, input logic [15:0] at);
      int w;
      @(posedge mclk);
      reset_mode <= mode;
      answer_at <= at;
      activate <= 1'h1;
      await(0, 20, w);
      @(posedge mclk);
      activate <= 1'h0;
      await(1, 3 * P + 20, w);
      check("supply up at first card clock", supply, 1);
      if (!mode)
      begin
         await(3, 16, w);
         check("reset high at T0", n_rise <= 2, 1);
      end
      await(2, 1700, w);
      check("line released by 200 clocks", n_rise <= 201, 1);
      check("released line level", data_o, 1);
      check("reset level before T1", card_rst, !mode);
      if (mode)
      begin
         await(3, RST_LOW * 8 + 80, w);
         check("reset low span", n_rise >= RST_LOW + 1, 1);
      end
   endtask

   task automatic expect_answer();
      int w;
      await(4, ATR_MAX * 8 + 200, w);
      check("answer accepted", answer_ok, 1);
      check("session active", active, 1);
      check("no early flag", err_early, 0);
      check("no timeout flag", err_none, 0);
   endtask

   // cause 0 removal, 1 processor request, 2 automatic power-down
   task automatic measure_deact(input int cause);
      int w;
      int t_clk;
      int t_dat;
      int t_sup;
      logic last_clk;
      check("reset held high in session", card_rst, 1);
      @(posedge mclk);
      case (cause)
         0: present <= 1'h0;
         1: power_down <= 1'h1;
         default: auto_pd <= 1'h1;
      endcase
      @(posedge mclk);
      power_down <= 1'h0;
      auto_pd <= 1'h0;
      #1;
      await(5, 40, w);
      // the two-flop synchroniser and request capture add three cycles
      if (cause == 0)
         check("removal to reset low", (w + 1 >= P) && (w + 1 <= P + 5), 1);
      else
         check("request to reset low", w, P);
      t_clk = 0;
      t_dat = 0;
      t_sup = 0;
      last_clk = card_clk;
      for (int k = 1; k <= 5 * P; k++)
      begin
         @(posedge mclk);
         #1;
         if (card_clk !== last_clk)
            t_clk = k;
         last_clk = card_clk;
         if (t_dat == 0 && data_oe && !data_o)
            t_dat = k;
         if (t_sup == 0 && !supply)
            t_sup = k;
      end
      check("clock stop after reset", t_clk >= P - 3 && t_clk <= P + 1, 1);
      check("data low after reset", t_dat >= 15 && t_dat <= 17, 1);
      check("supply off after reset", t_sup >= 22 && t_sup <= 26, 1);
      check("step order", t_clk < t_dat && t_dat < t_sup, 1);
      present <= 1'h1;
      repeat (4) @(posedge mclk);
   endtask

   task automatic check_etu(input logic sel, input int exp);
      int w;
      int start;
      @(posedge mclk);
      ratio_sel <= sel;
      await(7, 3200, w);
      @(posedge mclk);
      #1;
      await(7, 3200, w);
      start = n_rise;
      @(posedge mclk);
      #1;
      await(7, 3200, w);
      check("card clocks between ticks", n_rise - start, exp);
   endtask

   task automatic scen_low_reset_card();
      start_session(1'h1, 16'h044D);
      expect_answer();
      check_etu(1'h0, ETU_STD);
      check_etu(1'h1, ETU_FAST);
      measure_deact(1);
   endtask

   task automatic scen_all_causes();
      for (int c = 0; c < 3; c++)
      begin
         start_session(1'h0, 16'h01C3);
         expect_answer();
         measure_deact(c);
      end
   endtask

   task automatic scen_early_then_silent();
      int w;
      start_session(1'h1, 16'h012D);
      check("early answer flagged", err_early, 1);
      check("early answer refused", answer_ok, 0);
      await(4, ATR_MAX * 8 + 400, w);
      check("timeout flagged", err_none, 1);
      check("window kept open", n_rise >= RST_LOW + ATR_MAX, 1);
      await(6, 5 * P + 20, w);
      @(posedge mclk);
      err_clr <= 1'h1;
      @(posedge mclk);
      err_clr <= 1'h0;
      repeat (2) @(posedge mclk);
      #1;
      check("flags cleared", {err_early, err_none}, 0);
   endtask

   initial
   begin
      n_errors = 0;
      checks_done = 0;
      rst_n = 1'h0;
      activate = 1'h0;
      power_down = 1'h0;
      auto_pd = 1'h0;
      reset_mode = 1'h0;
      ratio_sel = 1'h0;
      err_clr = 1'h0;
      present = 1'h1;
      answer_at = 16'h0000;
      repeat (3) @(posedge mclk);
      rst_n <= 1'h1;
      // let the timebase period be measured before anything is timed
      repeat (80) @(posedge mclk);
      scen_low_reset_card();
      scen_all_causes();
      scen_early_then_silent();
      report_and_stop();
   end
endmodule
